/* lineif_pkg.sv */
// shared constants for the transmit input control block
//
// Operation
// - by default both rails are captured on the falling edge of the channel clock.
// - in host mode each channel may select rising or falling capture edge.
// - a captured one on the positive rail yields a positive line pulse.
// - a captured one on the negative rail yields a negative line pulse.
// - in single-rail mode the negative rail is held low and the zero encoder is on.
// - in dual-rail mode the negative rail is a separate negative data stream.
// - a high build-out select bypasses the build-out stage of that channel.
// - a low build-out select routes that channel through the build-out stage.
// - in E3 mode the build-out select has no effect.
// - the build-out select pin counts only in DS3 or STS-1 mode under strap control.
// - a high transmitters-off input tri-states the line outputs of all channels.
// - the transmitters-off input acts in host mode as well as strap mode.
package lineif_pkg;

  localparam int CH_N     = 4;
  localparam int CH_IDX_W = 2;
  localparam int AXI_AW   = 8;
  localparam int AXI_DW   = 32;
  localparam int STRB_W   = 4;
  localparam int BYTE_W   = 8;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [AXI_AW-1:0] ADDR_CTRL = 8'h00;
  localparam logic [AXI_AW-1:0] ADDR_MODE = 8'h04;
  localparam logic [AXI_AW-1:0] ADDR_STAT = 8'h08;

  localparam int CTRL_W    = 16;
  localparam int F_EDGE    = 0;
  localparam int F_SINGLE  = 4;
  localparam int F_SOFTOFF = 8;
  localparam int F_BYPASS  = 12;
  localparam logic [CTRL_W-1:0] CTRL_RST = 16'h0000;

  localparam int MODE_W  = 8;
  localparam int MODE_FW = 2;
  localparam logic [MODE_FW-1:0] MODE_E3   = 2'h0;
  localparam logic [MODE_FW-1:0] MODE_DS3  = 2'h1;
  localparam logic [MODE_FW-1:0] MODE_STS1 = 2'h2;
  localparam logic [MODE_W-1:0]  MODE_RST  = 8'h55;

  localparam int S_TIP   = 0;
  localparam int S_RING  = 4;
  localparam int S_OVF   = 8;
  localparam int S_HOST  = 12;
  localparam int S_OFF   = 13;
  localparam int S_EMPTY = 14;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // symbol fifo
  // ----------------------------------------------------------------
  localparam int FIFO_W   = 4;
  localparam int FIFO_D   = 16;
  localparam int W_CH_LSB = 2;
  localparam int W_POS    = 1;
  localparam int W_NEG    = 0;

endpackage : lineif_pkg

/* fifo_if.sv */
// valid/ready carrier between the capture logic and the symbol fifo
interface fifo_if #(
  parameter int W = 4
);
  logic         pushValid;
  logic         pushReady;
  logic [W-1:0] pushData;
  logic         popValid;
  logic         popReady;
  logic [W-1:0] popData;

  modport source (
    output pushValid,
    output pushData,
    input  pushReady,
    input  popValid,
    input  popData,
    output popReady
  );

  modport store (
    input  pushValid,
    input  pushData,
    output pushReady,
    output popValid,
    output popData,
    input  popReady
  );
endinterface : fifo_if

/* stream_fifo.sv */
// synchronous fifo with valid/ready on both sides
module stream_fifo
  import lineif_pkg::*;
#(
  parameter int W = FIFO_W,
  parameter int D = FIFO_D
) (
  input wire logic sys_clk,
  input wire logic nrst,
  fifo_if.store    bus
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       rdPtr;
    logic [AW-1:0]       wrPtr;
    logic [AW:0]         count;
  } fifo_s;

  fifo_s st_ff;
  fifo_s nxt_st;
  logic  doPush;
  logic  doPop;

  assign bus.pushReady = (st_ff.count != FULL_CNT);
  assign bus.popValid  = (st_ff.count != '0);
  assign bus.popData   = st_ff.mem[st_ff.rdPtr];
  assign doPush        = bus.pushValid & bus.pushReady;
  assign doPop         = bus.popValid & bus.popReady;

  always_comb begin
    nxt_st = st_ff;
    if (doPush) begin
      nxt_st.mem[st_ff.wrPtr] = bus.pushData;
      nxt_st.wrPtr = AW'(st_ff.wrPtr + 1'b1);
    end
    if (doPop) begin
      nxt_st.rdPtr = AW'(st_ff.rdPtr + 1'b1);
    end
    if (doPush && !doPop) begin
      nxt_st.count = (AW+1)'(st_ff.count + 1'b1);
    end else if (doPop && !doPush) begin
      nxt_st.count = (AW+1)'(st_ff.count - 1'b1);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  a_fifo_fills: assert property (@(posedge sys_clk) disable iff (!nrst)
    doPush && !doPop && st_ff.count == FULL_CNT - 1'b1 |=> !bus.pushReady)
    else $error("fifo did not report full");
  a_fifo_drains: assert property (@(posedge sys_clk) disable iff (!nrst)
    doPop && !doPush && st_ff.count == 1 |=> !bus.popValid)
    else $error("fifo did not report empty");

endmodule : stream_fifo

/* lineif_transmit_input_control.sv */
// transmit input capture, rail mapping and line control for four channels
//
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
module lineif_transmit_input_control
  import lineif_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                nrst,
  input  wire logic [CH_N-1:0]     txLineClock,
  input  wire logic [CH_N-1:0]     txPosRailIn,
  input  wire logic [CH_N-1:0]     txNegRailIn,
  input  wire logic [CH_N-1:0]     buildoutSelect,
  input  wire logic                transmittersOff,
  input  wire logic                hostOrStrapSelect,
  output wire logic [CH_N-1:0]     lineOutTip,
  output wire logic [CH_N-1:0]     lineOutTipOe,
  output wire logic [CH_N-1:0]     lineOutRing,
  output wire logic [CH_N-1:0]     lineOutRingOe,
  output wire logic [CH_N-1:0]     buildoutBypass,
  output wire logic [CH_N-1:0]     encoderEnable,
  input  wire logic [AXI_AW-1:0]   awaddr,
  input  wire logic                awvalid,
  output wire logic                awready,
  input  wire logic [AXI_DW-1:0]   wdata,
  input  wire logic [STRB_W-1:0]   wstrb,
  input  wire logic                wvalid,
  output wire logic                wready,
  output wire logic [1:0]          bresp,
  output wire logic                bvalid,
  input  wire logic                bready,
  input  wire logic [AXI_AW-1:0]   araddr,
  input  wire logic                arvalid,
  output wire logic                arready,
  output wire logic [AXI_DW-1:0]   rdata,
  output wire logic [1:0]          rresp,
  output wire logic                rvalid,
  input  wire logic                rready
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [CH_N-1:0]   clkS1;
    logic [CH_N-1:0]   clkS2;
    logic [CH_N-1:0]   clkS3;
    logic [CH_N-1:0]   posS1;
    logic [CH_N-1:0]   posS2;
    logic [CH_N-1:0]   negS1;
    logic [CH_N-1:0]   negS2;
    logic [CH_N-1:0]   selS1;
    logic [CH_N-1:0]   selS2;
    logic              offS1;
    logic              offS2;
    logic              hostS1;
    logic              hostS2;
    logic [CH_N-1:0]   pendV;
    logic [CH_N-1:0]   pendPos;
    logic [CH_N-1:0]   pendNeg;
    logic [CH_N-1:0]   ovf;
    logic [CH_N-1:0]   tip;
    logic [CH_N-1:0]   ring;
    logic [CH_N-1:0]   oe;
    logic [CH_N-1:0]   bypass;
    logic [CH_N-1:0]   encEn;
    logic [CTRL_W-1:0] ctrl;
    logic [MODE_W-1:0] mode;
    logic              awHeld;
    logic [AXI_AW-1:0] awAddr;
    logic              wHeld;
    logic [AXI_DW-1:0] wData;
    logic [STRB_W-1:0] wStrb;
    logic              awRdy;
    logic              wRdy;
    logic              bValid;
    logic [1:0]        bResp;
    logic              arRdy;
    logic              rValid;
    logic [AXI_DW-1:0] rData;
    logic [1:0]        rResp;
  } state_s;

  state_s st_ff;
  state_s nxt_st;

  fifo_if #(.W(FIFO_W)) fifoBus ();

  stream_fifo #(
    .W (FIFO_W),
    .D (FIFO_D)
  ) u_fifo (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .bus     (fifoBus)
  );

  function automatic logic [AXI_DW-1:0] strbMask(
    input logic [STRB_W-1:0] s
  );
    logic [AXI_DW-1:0] m;
    m = '0;
    for (int b = 0; b < STRB_W; b++) begin
      m[BYTE_W*b +: BYTE_W] = {BYTE_W{s[b]}};
    end
    return m;
  endfunction : strbMask

  // ----------------------------------------------------------------
  // edge detection on the sampled transmit clocks
  // ----------------------------------------------------------------
  logic [CH_N-1:0] riseEdge;
  logic [CH_N-1:0] fallEdge;
  logic [CH_N-1:0] useRise;
  logic [CH_N-1:0] capEdge;
  logic            popFire;
  logic [CH_IDX_W-1:0] popCh;

  assign riseEdge = st_ff.clkS2 & ~st_ff.clkS3;
  assign fallEdge = ~st_ff.clkS2 & st_ff.clkS3;
  assign useRise  = {CH_N{st_ff.hostS2}} & st_ff.ctrl[F_EDGE +: CH_N];
  assign capEdge  = (useRise & riseEdge) | (~useRise & fallEdge);
  assign popFire  = fifoBus.popValid & fifoBus.popReady;
  // drain stalls while transmitters are off
  assign fifoBus.popReady = !st_ff.offS2;
  assign popCh    = fifoBus.popData[W_CH_LSB +: CH_IDX_W];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [AXI_DW-1:0]   mask;
    logic [AXI_DW-1:0]   merged;
    logic [AXI_DW-1:0]   rd;
    logic [1:0]          rdResp;
    logic [CH_IDX_W-1:0] pushCh;
    logic                found;
    logic                notE3;
    logic                sel;
    mask   = strbMask(st_ff.wStrb);
    merged = (AXI_DW'(st_ff.ctrl) & ~mask) | (st_ff.wData & mask);
    rd     = '0;
    rdResp = RESP_OKAY;
    pushCh = '0;
    found  = 1'b0;
    notE3  = 1'b0;
    sel    = 1'b0;
    nxt_st = st_ff;

    // pin synchronisers
    nxt_st.clkS1  = txLineClock;
    nxt_st.clkS2  = st_ff.clkS1;
    nxt_st.clkS3  = st_ff.clkS2;
    nxt_st.posS1  = txPosRailIn;
    nxt_st.posS2  = st_ff.posS1;
    nxt_st.negS1  = txNegRailIn;
    nxt_st.negS2  = st_ff.negS1;
    nxt_st.selS1  = buildoutSelect;
    nxt_st.selS2  = st_ff.selS1;
    nxt_st.offS1  = transmittersOff;
    nxt_st.offS2  = st_ff.offS1;
    nxt_st.hostS1 = hostOrStrapSelect;
    nxt_st.hostS2 = st_ff.hostS1;

    // register write: both halves held, response slot free
    if (st_ff.bValid && bready) begin
      nxt_st.bValid = 1'b0;
    end
    if (awvalid && st_ff.awRdy) begin
      nxt_st.awHeld = 1'b1;
      nxt_st.awAddr = awaddr;
    end
    if (wvalid && st_ff.wRdy) begin
      nxt_st.wHeld = 1'b1;
      nxt_st.wData = wdata;
      nxt_st.wStrb = wstrb;
    end
    if (st_ff.awHeld && st_ff.wHeld && !st_ff.bValid) begin
      nxt_st.awHeld = 1'b0;
      nxt_st.wHeld  = 1'b0;
      nxt_st.bValid = 1'b1;
      nxt_st.bResp  = RESP_OKAY;
      if (st_ff.awAddr == ADDR_CTRL) begin
        nxt_st.ctrl = merged[CTRL_W-1:0];
      end else if (st_ff.awAddr == ADDR_MODE) begin
        nxt_st.mode = (st_ff.mode & ~mask[MODE_W-1:0])
                    | (st_ff.wData[MODE_W-1:0] & mask[MODE_W-1:0]);
      end else if (st_ff.awAddr == ADDR_STAT) begin
        nxt_st.ovf = st_ff.ovf
                   & ~(st_ff.wData[S_OVF +: CH_N] & mask[S_OVF +: CH_N]);
      end else begin
        nxt_st.bResp = RESP_SLVERR;
      end
    end
    nxt_st.awRdy = !nxt_st.awHeld;
    nxt_st.wRdy  = !nxt_st.wHeld;

    // register read
    case (araddr)
      ADDR_CTRL: rd[CTRL_W-1:0] = st_ff.ctrl;
      ADDR_MODE: rd[MODE_W-1:0] = st_ff.mode;
      ADDR_STAT: begin
        rd[S_TIP +: CH_N]  = st_ff.tip;
        rd[S_RING +: CH_N] = st_ff.ring;
        rd[S_OVF +: CH_N]  = st_ff.ovf;
        rd[S_HOST]         = st_ff.hostS2;
        rd[S_OFF]          = st_ff.offS2;
        rd[S_EMPTY]        = !fifoBus.popValid;
      end
      default: rdResp = RESP_SLVERR;
    endcase
    if (st_ff.rValid && rready) begin
      nxt_st.rValid = 1'b0;
    end
    if (arvalid && st_ff.arRdy) begin
      nxt_st.rValid = 1'b1;
      nxt_st.rData  = rd;
      nxt_st.rResp  = rdResp;
    end
    nxt_st.arRdy = !nxt_st.rValid;

    // offer the lowest pending channel to the fifo
    for (int i = 0; i < CH_N; i++) begin
      if (st_ff.pendV[i] && !found) begin
        found  = 1'b1;
        pushCh = CH_IDX_W'(i);
      end
    end
    fifoBus.pushValid = found;
    fifoBus.pushData  = {pushCh, st_ff.pendPos[pushCh],
                         st_ff.pendNeg[pushCh]};
    if (found && fifoBus.pushReady) begin
      nxt_st.pendV[pushCh] = 1'b0;
    end

    // capture on the chosen edge; set beats a clear in the same cycle
    for (int i = 0; i < CH_N; i++) begin
      if (capEdge[i]) begin
        if (nxt_st.pendV[i]) begin
          nxt_st.ovf[i] = 1'b1;
        end
        nxt_st.pendV[i]   = 1'b1;
        nxt_st.pendPos[i] = st_ff.posS2[i];
        nxt_st.pendNeg[i] = st_ff.negS2[i]
                          & ~st_ff.ctrl[F_SINGLE + i];
      end
    end

    // line pulses from the drained symbol
    if (popFire) begin
      nxt_st.tip[popCh]  = fifoBus.popData[W_POS];
      nxt_st.ring[popCh] = fifoBus.popData[W_NEG];
    end

    // line enables, build-out and encoder control
    nxt_st.oe = ~({CH_N{st_ff.offS2}}
              | ({CH_N{st_ff.hostS2}} & st_ff.ctrl[F_SOFTOFF +: CH_N]));
    for (int i = 0; i < CH_N; i++) begin
      notE3 = st_ff.mode[MODE_FW*i +: MODE_FW] != MODE_E3;
      sel   = st_ff.hostS2 ? st_ff.ctrl[F_BYPASS + i]
                           : st_ff.selS2[i];
      nxt_st.bypass[i] = notE3 & sel;
    end
    nxt_st.encEn = st_ff.ctrl[F_SINGLE +: CH_N];
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_ff       <= '0;
      st_ff.ctrl  <= CTRL_RST;
      st_ff.mode  <= MODE_RST;
      st_ff.awRdy <= 1'b1;
      st_ff.wRdy  <= 1'b1;
      st_ff.arRdy <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign lineOutTip     = st_ff.tip;
  assign lineOutRing    = st_ff.ring;
  assign lineOutTipOe   = st_ff.oe;
  assign lineOutRingOe  = st_ff.oe;
  assign buildoutBypass = st_ff.bypass;
  assign encoderEnable  = st_ff.encEn;
  assign awready        = st_ff.awRdy;
  assign wready         = st_ff.wRdy;
  assign bvalid         = st_ff.bValid;
  assign bresp          = st_ff.bResp;
  assign arready        = st_ff.arRdy;
  assign rvalid         = st_ff.rValid;
  assign rdata          = st_ff.rData;
  assign rresp          = st_ff.rResp;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_fall_default: assert property (
    !st_ff.hostS2 && fallEdge[0]
    |=> st_ff.pendV[0] && st_ff.pendPos[0] == $past(st_ff.posS2[0]))
    else $error("falling edge capture missed");
  a_rise_select: assert property (
    st_ff.hostS2 && st_ff.ctrl[F_EDGE] && riseEdge[0] |=> st_ff.pendV[0])
    else $error("rising edge capture missed");
  a_pos_pulse: assert property (
    popFire && popCh == '0 && fifoBus.popData[W_POS] |=> st_ff.tip[0])
    else $error("positive pulse not sent");
  a_neg_pulse: assert property (
    popFire && popCh == '0 && fifoBus.popData[W_NEG] |=> st_ff.ring[0])
    else $error("negative pulse not sent");
  a_single_mask: assert property (
    st_ff.ctrl[F_SINGLE] && capEdge[0] |=> !st_ff.pendNeg[0])
    else $error("negative rail not masked in single rail");
  a_dual_pass: assert property (
    !st_ff.ctrl[F_SINGLE] && capEdge[0] && st_ff.negS2[0]
    |=> st_ff.pendNeg[0])
    else $error("negative rail dropped in dual rail");
  a_bypass_strap: assert property (
    !st_ff.hostS2 && st_ff.mode[MODE_FW-1:0] != MODE_E3 && st_ff.selS2[0]
    |=> st_ff.bypass[0])
    else $error("build-out not bypassed");
  a_buildout_on: assert property (
    !st_ff.hostS2 && !st_ff.selS2[0] |=> !st_ff.bypass[0])
    else $error("build-out wrongly bypassed");
  a_e3_ignore: assert property (
    st_ff.mode[MODE_FW-1:0] == MODE_E3 |=> !st_ff.bypass[0])
    else $error("build-out select acted in E3 mode");
  a_host_pin: assert property (
    st_ff.hostS2 && !st_ff.ctrl[F_BYPASS] |=> !st_ff.bypass[0])
    else $error("build-out pin acted in host mode");
  a_off_all: assert property (
    transmittersOff [*4] |=> st_ff.oe == '0 && !popFire)
    else $error("line outputs not tri-stated");
  a_off_host: assert property (
    st_ff.hostS2 && st_ff.offS2 |=> st_ff.oe == '0)
    else $error("transmitters-off ignored in host mode");
  a_four_chan: assert property (
    capEdge[3] |=> st_ff.pendV[3])
    else $error("channel three capture missed");

endmodule : lineif_transmit_input_control

/* tx_framer_model.sv */
// framer model driving transmit clocks and rail data
module tx_framer_model
  import lineif_pkg::*;
(
  input  wire logic       sys_clk,
  output logic [CH_N-1:0] txLineClock,
  output logic [CH_N-1:0] txPosRailIn,
  output logic [CH_N-1:0] txNegRailIn
);
  timeunit 1ns;
  timeprecision 1ps;

  // clock stands still between symbols
  initial begin
    txLineClock = '1;
    txPosRailIn = '0;
    txNegRailIn = '0;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wait_cyc

  // one symbol on one channel, far below the sys_clk rate
  task automatic send(input int ch, input logic p, input logic n,
                      input logic rise, input logic single);
    if (txLineClock[ch] !== ~rise) begin
      txLineClock[ch] <= ~rise;
      wait_cyc(4);
    end
    txPosRailIn[ch] <= p;
    txNegRailIn[ch] <= single ? 1'b0 : n;
    wait_cyc(4);
    txLineClock[ch] <= rise;
    wait_cyc(4);
    // hold time over: stale inverse, negative rail stays low in single rail
    txPosRailIn[ch] <= ~p;
    txNegRailIn[ch] <= single ? 1'b0 : ~n;
  endtask : send
endmodule : tx_framer_model

/* lineif_transmit_input_control_tb.sv */
// self-checking bench for the transmit input control block
module lineif_transmit_input_control_tb
  import lineif_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              sys_clk, nrst, transmittersOff, hostOrStrapSelect;
  logic [CH_N-1:0]   txLineClock, txPosRailIn, txNegRailIn, buildoutSelect;
  logic [CH_N-1:0]   lineOutTip, lineOutTipOe, lineOutRing, lineOutRingOe;
  logic [CH_N-1:0]   buildoutBypass, encoderEnable;
  logic [AXI_AW-1:0] awaddr, araddr;
  logic [AXI_DW-1:0] wdata, rdata;
  logic [STRB_W-1:0] wstrb;
  logic [1:0]        bresp, rresp;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready;
  int                errors, testsRun;

  lineif_transmit_input_control dut (
    .sys_clk(sys_clk), .nrst(nrst), .txLineClock(txLineClock),
    .txPosRailIn(txPosRailIn), .txNegRailIn(txNegRailIn),
    .buildoutSelect(buildoutSelect), .transmittersOff(transmittersOff),
    .hostOrStrapSelect(hostOrStrapSelect), .lineOutTip(lineOutTip),
    .lineOutTipOe(lineOutTipOe), .lineOutRing(lineOutRing),
    .lineOutRingOe(lineOutRingOe), .buildoutBypass(buildoutBypass),
    .encoderEnable(encoderEnable), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready)
  );

  tx_framer_model fm (
    .sys_clk(sys_clk), .txLineClock(txLineClock),
    .txPosRailIn(txPosRailIn), .txNegRailIn(txNegRailIn)
  );

  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a; wdata <= d; wstrb <= 4'hF;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!(bvalid === 1'b1));
    bready <= 1'b0;
    check(bresp, (a > ADDR_STAT) ? RESP_SLVERR : RESP_OKAY);
    // let an edge pass so a following request never re-drives bready now
    cyc(1);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
    end while (!(rvalid === 1'b1));
    d = rdata;
    rready <= 1'b0;
    check(rresp, (a > ADDR_STAT) ? RESP_SLVERR : RESP_OKAY);
    cyc(1);
  endtask : rd

  task automatic pins(input logic host, input logic off);
    hostOrStrapSelect <= host;
    transmittersOff <= off;
    cyc(5);
  endtask : pins

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] d;
    rd(ADDR_CTRL, d);
    check(d, 32'h0000_0000);
    rd(ADDR_MODE, d);
    check(d, 32'h0000_0055);
    rd(8'h0C, d);
    check(d, 32'h0000_0000);
    wr(8'h10, 32'hFFFF_FFFF);
    check(encoderEnable, 4'h0);
    check(lineOutTipOe, 4'hF);
  endtask : t_reset

  task automatic t_capture(input logic rise);
    for (int ch = 0; ch < CH_N; ch++) begin
      for (int k = 3; k >= 0; k--) begin
        fm.send(ch, k[1], k[0], rise, 1'b0);
        cyc(8);
        check(lineOutTip[ch], k[1]);
        check(lineOutRing[ch], k[0]);
      end
    end
    check(lineOutRingOe, 4'hF);
  endtask : t_capture

  task automatic t_single();
    wr(ADDR_CTRL, 32'h0000_00F0);
    check(encoderEnable, 4'hF);
    fm.send(2, 1'b1, 1'b0, 1'b0, 1'b1);
    cyc(8);
    check({lineOutTip[2], lineOutRing[2]}, 2'b10);
    wr(ADDR_CTRL, 32'h0000_0000);
    check(encoderEnable, 4'h0);
  endtask : t_single

  task automatic t_buildout();
    buildoutSelect <= 4'b1010;
    cyc(5);
    check(buildoutBypass, 4'b1010);
    wr(ADDR_MODE, 32'h0000_0054);
    buildoutSelect <= 4'hF;
    cyc(5);
    check(buildoutBypass, 4'hE);
    wr(ADDR_MODE, 32'h0000_00AA);
    cyc(3);
    check(buildoutBypass, 4'hF);
    pins(1'b1, 1'b0);
    check(buildoutBypass, 4'h0);
    buildoutSelect <= 4'h0;
    wr(ADDR_CTRL, 32'h0000_F000);
    cyc(3);
    check(buildoutBypass, 4'hF);
    wr(ADDR_CTRL, 32'h0000_0000);
    wr(ADDR_MODE, 32'h0000_0055);
    pins(1'b0, 1'b0);
  endtask : t_buildout

  task automatic t_off();
    pins(1'b0, 1'b1);
    check({lineOutTipOe, lineOutRingOe}, 8'h00);
    pins(1'b0, 1'b0);
    check(lineOutTipOe, 4'hF);
    pins(1'b1, 1'b1);
    check({lineOutTipOe, lineOutRingOe}, 8'h00);
    pins(1'b1, 1'b0);
    wr(ADDR_CTRL, 32'h0000_0500);
    cyc(3);
    check(lineOutTipOe, 4'hA);
    wr(ADDR_CTRL, 32'h0000_0000);
    pins(1'b0, 1'b0);
  endtask : t_off

  task automatic t_fifo();
    logic [31:0] d;
    pins(1'b0, 1'b1);
    for (int i = 0; i < 20; i++) begin
      fm.send(0, i[0], ~i[0], 1'b0, 1'b0);
    end
    cyc(8);
    rd(ADDR_STAT, d);
    check(d & 32'h0000_7100, 32'h0000_2100);
    pins(1'b0, 1'b0);
    cyc(40);
    check({lineOutTip[0], lineOutRing[0]}, 2'b10);
    rd(ADDR_STAT, d);
    check(d & 32'h0000_7100, 32'h0000_4100);
    wr(ADDR_STAT, 32'h0000_0100);
    rd(ADDR_STAT, d);
    check(d & 32'h0000_0100, 32'h0000_0000);
  endtask : t_fifo

  // ------------------------------------------------------------------
  // run control
  // ------------------------------------------------------------------
  task automatic complete_run();
    if (errors == 0 && testsRun > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (30000) @(posedge sys_clk);
    errors++;
    complete_run();
  end

  initial begin
    errors = 0;
    testsRun = 0;
    nrst = 1'b0;
    transmittersOff = 1'b0;
    hostOrStrapSelect = 1'b0;
    buildoutSelect = 4'h0;
    awaddr = '0; wdata = '0; wstrb = '0; awvalid = 1'b0; wvalid = 1'b0;
    bready = 1'b0; araddr = '0; arvalid = 1'b0; rready = 1'b0;
    cyc(6);
    nrst <= 1'b1;
    cyc(5);
    t_reset();
    wr(ADDR_CTRL, 32'h0000_000F);
    t_capture(1'b0);
    pins(1'b1, 1'b0);
    t_capture(1'b1);
    wr(ADDR_CTRL, 32'h0000_0000);
    t_capture(1'b0);
    pins(1'b0, 1'b0);
    t_single();
    t_buildout();
    t_off();
    t_fifo();
    complete_run();
  end
endmodule : lineif_transmit_input_control_tb
